// *** sdm_regs.svh ***
// register offsets, fields and timing counts of the step and direction host
`ifndef SDM_REGS_SVH
`define SDM_REGS_SVH
`define SDM_ADDR_CTRL     4'h0
`define SDM_ADDR_STEP     4'h1
`define SDM_ADDR_STATUS   4'h2
`define SDM_CTRL_ENABLE   0
`define SDM_CTRL_SEQ_RST  1
`define SDM_CTRL_MODE_LO  2
`define SDM_CTRL_MODE_HI  3
`define SDM_STEP_DIR      16
`define SDM_CNT_W         16
`define SDM_HIGH_NS       10000
`define SDM_CLK_NS        20
`define SDM_SETUP_CYC     4
`define SDM_CTRL_RST      32'h0000_0005
`endif

// *** sdm_pkg.sv ***
// types shared by the step and direction host
package sdm_pkg;
    typedef enum logic [1:0] {
        SDM_RES_FULL = 2'h0,
        SDM_RES_HALF = 2'h1,
        SDM_RES_EIGHTH = 2'h2,
        SDM_RES_SIXTEENTH = 2'h3
    } sdm_res_t;
    typedef struct packed {
        logic step;
        logic dir;
        logic enable;
        logic sequencer_reset_n;
        logic step_res_sel0;
        logic step_res_sel1;
    } sdm_pins_t;
endpackage

// *** sdm_host.sv ***
// step and direction host controller driven over avalon-mm
`timescale 1ns/1ps
`include "sdm_regs.svh"
module sdm_host #(
    parameter int HIGH_CYC = (`SDM_HIGH_NS + `SDM_CLK_NS - 1) / `SDM_CLK_NS,
    parameter int LOW_CYC  = (`SDM_HIGH_NS + `SDM_CLK_NS - 1) / `SDM_CLK_NS
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // avalon-mm slave
    input  wire logic [3:0]        avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o,
    // pins to and from the driver board
    output sdm_pkg::sdm_pins_t     pins_o,
    input  wire logic              thermal_fault_i
);
    // step sequencer states
    typedef enum logic [3:0] {
        SDM_IDLE  = 4'b0001,
        SDM_SETUP = 4'b0010,
        SDM_HIGH  = 4'b0100,
        SDM_LOW   = 4'b1000
    } sdm_state_t;

    sdm_state_t             st_q, st_d;      // sequencer state
    logic [`SDM_CNT_W-1:0]  cnt_q, cnt_d;    // phase timer
    logic [`SDM_CNT_W-1:0]  left_q, left_d;  // steps still to issue
    logic                   dir_q, dir_d;    // direction level
    logic [3:0]             ctrl_q;          // enable, reset, mode
    logic [`SDM_CNT_W-1:0]  done_q;          // steps issued total
    logic                   rd_q;            // read answered flag
    logic [31:0]            rdata_q;         // read data flop
    logic                   th_s1_q, th_s2_q; // thermal synchroniser
    logic                   step_q;          // step pin flop

    // assertions below share the system clock and reset
    default clocking sdm_cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // mode to select lines, fixed table
    function automatic logic [1:0] sdm_sel(input logic [1:0] m);
        unique case (m)
            sdm_pkg::SDM_RES_FULL:      sdm_sel = 2'h0;
            sdm_pkg::SDM_RES_HALF:      sdm_sel = 2'h1;
            sdm_pkg::SDM_RES_EIGHTH:    sdm_sel = 2'h3;
            sdm_pkg::SDM_RES_SIXTEENTH: sdm_sel = 2'h2;
        endcase
    endfunction

    // decode of bus accesses
    wire busy     = (st_q != SDM_IDLE);
    wire wr_ctrl  = avs_write_i && avs_address_i == `SDM_ADDR_CTRL;
    wire wr_step  = avs_write_i && avs_address_i == `SDM_ADDR_STEP;
    wire step_req = wr_step && !busy && ctrl_q[`SDM_CTRL_ENABLE];
    wire [1:0] sel = sdm_sel(ctrl_q[`SDM_CTRL_MODE_HI:`SDM_CTRL_MODE_LO]);
    wire [31:0] status = {13'h0, th_s2_q, busy,
                          dir_q, done_q};
    wire [31:0] rd_mux =
        (avs_address_i == `SDM_ADDR_CTRL)   ? {28'h0, ctrl_q} :
        (avs_address_i == `SDM_ADDR_STEP)   ? {16'h0, left_q} :
        (avs_address_i == `SDM_ADDR_STATUS) ? status : 32'h0;

    // reads wait one cycle for registered data; writes take at once
    assign avs_waitrequest_o = avs_read_i && !rd_q;
    assign avs_readdata_o    = rdata_q;

    // pins from flops
    assign pins_o.step              = step_q;
    assign pins_o.dir               = dir_q;
    assign pins_o.enable            = ctrl_q[`SDM_CTRL_ENABLE];
    assign pins_o.sequencer_reset_n = ~ctrl_q[`SDM_CTRL_SEQ_RST];
    // each select line only wins while its own mode strap is off; both straps on sit at full step
    assign pins_o.step_res_sel0     = sel[0];
    assign pins_o.step_res_sel1     = sel[1];

    // step sequencer next state
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        left_d = left_q;
        dir_d  = dir_q;
        unique case (st_q)
            SDM_IDLE: begin
                if (step_req && avs_writedata_i[`SDM_CNT_W-1:0] != '0) begin
                    dir_d  = avs_writedata_i[`SDM_STEP_DIR];
                    left_d = avs_writedata_i[`SDM_CNT_W-1:0];
                    cnt_d  = `SDM_CNT_W'(`SDM_SETUP_CYC);
                    st_d   = SDM_SETUP;
                end
            end
            SDM_SETUP: begin
                // direction settles before the rising edge
                if (!ctrl_q[`SDM_CTRL_ENABLE]) begin
                    // enable dropped before the first pulse: drop job
                    left_d = '0;
                    st_d   = SDM_IDLE;
                end else if (cnt_q <= 1) begin
                    cnt_d = `SDM_CNT_W'(HIGH_CYC);
                    st_d  = SDM_HIGH;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            SDM_HIGH: begin
                if (cnt_q <= 1) begin
                    cnt_d  = `SDM_CNT_W'(LOW_CYC);
                    left_d = left_q - 1'b1;
                    st_d   = SDM_LOW;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            SDM_LOW: begin
                if (cnt_q > 1) begin
                    cnt_d = cnt_q - 1'b1;
                end else if (left_q != '0 && ctrl_q[`SDM_CTRL_ENABLE]) begin
                    cnt_d = `SDM_CNT_W'(HIGH_CYC);
                    st_d  = SDM_HIGH;
                end else begin
                    left_d = '0;
                    st_d   = SDM_IDLE;
                end
            end
        endcase
    end

    // sequencer and pin flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q   <= SDM_IDLE;
            cnt_q  <= '0;
            left_q <= '0;
            dir_q  <= 1'b0;
            step_q <= 1'b0;
            done_q <= '0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            left_q <= left_d;
            dir_q  <= dir_d;
            step_q <= (st_d == SDM_HIGH);
            if (st_q == SDM_HIGH && st_d == SDM_LOW)
                done_q <= done_q + 1'b1;
        end
    end

    // control register; default half step, enabled
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            ctrl_q <= 4'(`SDM_CTRL_RST);
        // only our enable, reset and select lines move; board straps stay as powered up
        else if (wr_ctrl)
            ctrl_q <= avs_writedata_i[3:0];
    end

    // read answer and thermal synchroniser
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_q    <= 1'b0;
            rdata_q <= '0;
            th_s1_q <= 1'b0;
            th_s2_q <= 1'b0;
        end else begin
            rd_q    <= avs_read_i && !rd_q;
            rdata_q <= rd_mux;
            th_s1_q <= thermal_fault_i;
            th_s2_q <= th_s1_q;
        end
    end

    // high phase lasts the full minimum width
    int hcnt_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            hcnt_q <= 0;
        else
            hcnt_q <= step_q ? hcnt_q + 1 : 0;
    end
    a_step_width: assert property (
        $fell(step_q) |-> hcnt_q >= HIGH_CYC)
        else $error("step high too short");
    a_dir_stable: assert property (
        step_q |-> $stable(dir_q))
        else $error("direction moved during step");
    a_dir_setup: assert property (
        $rose(step_q) |-> $past(dir_q, `SDM_SETUP_CYC) == dir_q)
        else $error("direction changed within setup time");
    a_step_enable: assert property (
        $rose(step_q) |-> $past(ctrl_q[`SDM_CTRL_ENABLE]))
        else $error("step issued while disabled");
    a_step_count: assert property (
        $fell(step_q) |-> done_q == $past(done_q) + 1'b1)
        else $error("step not counted");
    a_mode_table: assert property (
        ctrl_q[3:2] == 2'h1 |-> sel == 2'h1)
        else $error("half step select wrong");
    a_seq_reset: assert property (
        wr_ctrl && avs_writedata_i[`SDM_CTRL_SEQ_RST]
        |=> !pins_o.sequencer_reset_n)
        else $error("sequencer reset not driven");
    a_mode_sel: assert property (
        wr_ctrl |=> sel == sdm_sel($past(avs_writedata_i[3:2])))
        else $error("mode select mismatch");
    // main scenarios: one step, a train, overheat, sequencer held
    c_one_step: cover property (
        $rose(step_q));
    c_two_steps: cover property (
        $fell(step_q) ##[1:1000] $rose(step_q));
    c_thermal: cover property (
        $rose(th_s2_q));
    c_seq_hold: cover property (
        !pins_o.sequencer_reset_n);
endmodule

// *** sdm_drv_model.sv ***
// behavioural model of the driver board seen by the host
`timescale 1ns/1ps
module sdm_drv_model #(
    parameter realtime    MIN_HIGH_NS = 10000.0,
    parameter realtime    SETUP_NS    = 20.0,
    // bit k set: switch k+1 on; 1,2 mode, 3,4 torque, 5,6 decay
    // default is half step, full torque, no decay
    parameter logic [5:0] STRAP_ON    = 6'h02
) (
    // pins from the host and fault control
    input  wire sdm_pkg::sdm_pins_t pins_i,
    input  wire logic               overheat_i,
    // indicator and observations
    output logic                    thermal_o,
    output int                      pos_o = 0,
    output int                      bad_o = 0,
    output logic [1:0]              res_o,
    output int                      torque_o,
    output int                      decay_o
);
    realtime t_rise = 0.0;  // time of last step rise
    realtime t_dir  = 0.0;  // time of last direction change
    // straps fixed at power up; an on switch pulls its line low
    localparam logic [5:0] STRAP_LVL = ~STRAP_ON;
    // a mode switch that is on holds its line low over the host
    wire sel0 = pins_i.step_res_sel0 & STRAP_LVL[0];
    wire sel1 = pins_i.step_res_sel1 & STRAP_LVL[1];
    // red indicator follows the die temperature
    assign thermal_o = overheat_i;
    // fixed select table: 00 full, 01 half, 11 eighth, 10 sixteenth
    assign res_o = {sel1, sel1 ^ sel0};
    // torque from switches 3,4: 100, 75, 50, 20 percent
    assign torque_o = (STRAP_LVL[3:2] == 2'h3) ? 100 :
                      (STRAP_LVL[3:2] == 2'h2) ? 75 :
                      (STRAP_LVL[3:2] == 2'h1) ? 50 : 20;
    // decay from switches 5,6: 0, 25, 50, 100 percent
    assign decay_o = (STRAP_LVL[5:4] == 2'h3) ? 0 :
                     (STRAP_LVL[5:4] == 2'h2) ? 25 :
                     (STRAP_LVL[5:4] == 2'h1) ? 50 : 100;
    // direction changes are timed for the setup check
    always @(pins_i.dir) t_dir = $realtime;
    // one step per rise, direction taken at the rise
    always @(posedge pins_i.step) begin
        t_rise = $realtime;
        if ($realtime - t_dir < SETUP_NS) bad_o = bad_o + 1;
        // held sequencer, off drivers or overheat: no motion
        if (pins_i.enable && pins_i.sequencer_reset_n && !overheat_i)
            pos_o = pins_i.dir ? pos_o + 1 : pos_o - 1;
    end
    // too short a pulse counts as a fault
    always @(negedge pins_i.step)
        if ($realtime - t_rise < MIN_HIGH_NS) bad_o = bad_o + 1;
endmodule

// *** tb.sv ***
// self-checking bench for the step and direction host
`timescale 1ns/1ps
`include "sdm_regs.svh"
module tb;
    logic               clk_i     = 1'b0;  // 50 MHz clock
    logic               rst_n_i   = 1'b0;  // async reset
    logic [3:0]         adr       = 4'h0;  // bus address
    logic               rd        = 1'b0;  // read request
    logic               wr        = 1'b0;  // write request
    logic [31:0]        wdat      = 32'h0; // write data
    logic [31:0]        rdat;              // read data
    logic               wait_r;            // waitrequest
    logic               overheat  = 1'b0;  // board overtemperature
    logic               thermal;           // indicator to host
    sdm_pkg::sdm_pins_t pins;              // host to board pins
    int                 pos;               // board position
    int                 bad;               // board-side timing faults
    logic [1:0]         res;               // decoded resolution
    int                 torque;            // board torque percent
    int                 decay;             // board decay percent
    logic [1:0]         res_dflt;          // resolution, factory straps
    int                 torque_dflt;       // torque, factory straps
    int                 decay_dflt;        // decay, factory straps
    int                 fail_count = 0;    // mismatches
    int                 checked    = 0;    // comparisons
    logic [31:0]        r;                 // scratch read value
    always #10 clk_i = ~clk_i;
    // short pulses keep the run brief
    sdm_host #(.HIGH_CYC(4), .LOW_CYC(4)) i_sdm_host (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wait_r), .pins_o(pins), .thermal_fault_i(thermal));
    // mode straps off so the host lines rule; torque 75, decay 25
    sdm_drv_model #(.MIN_HIGH_NS(80.0), .STRAP_ON(6'h14)) i_sdm_drv_model (
        .pins_i(pins), .overheat_i(overheat), .thermal_o(thermal),
        .pos_o(pos), .bad_o(bad), .res_o(res), .torque_o(torque),
        .decay_o(decay));
    // second board left at its factory straps
    sdm_drv_model i_sdm_drv_dflt (.pins_i(pins), .overheat_i(overheat),
        .thermal_o(), .pos_o(), .bad_o(), .res_o(res_dflt),
        .torque_o(torque_dflt), .decay_o(decay_dflt));
    // compare and report
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    // avalon write, held until waitrequest is low
    task automatic bus_wr(logic [3:0] a, logic [31:0] d);
        @(posedge clk_i);
        adr <= a;
        wdat <= d;
        wr <= 1'b1;
        do @(posedge clk_i); while (wait_r !== 1'b0);
        wr <= 1'b0;
    endtask
    // avalon read, data taken at the accepting edge
    task automatic bus_rd(logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        adr <= a;
        rd <= 1'b1;
        do @(posedge clk_i); while (wait_r !== 1'b0);
        d = rdat;
        rd <= 1'b0;
    endtask
    // poll status until the step job is over
    task automatic wait_idle();
        int n;
        n = 0;
        r = 32'h0002_0000;
        while (r[17] !== 1'b0 && n < 100) begin
            bus_rd(`SDM_ADDR_STATUS, r);
            n++;
        end
        chk("busy", 32'h0, 32'(r[17]));
    endtask
    // verdict and end of run
    task automatic finish_test();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // run takes a few microseconds; far longer means a hang
    initial begin
        #100us;
        fail_count++;
        finish_test();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        chk("rst res", 32'h1, 32'(res));
        chk("rst en", 32'h1, 32'(pins.enable));
        chk("dflt res", 32'h1, 32'(res_dflt));
        chk("dflt torque", 32'h64, 32'(torque_dflt));
        chk("dflt decay", 32'h0, 32'(decay_dflt));
        chk("torque", 32'h4B, 32'(torque));
        chk("decay", 32'h19, 32'(decay));
        rst_n_i <= 1'b1;
        bus_rd(`SDM_ADDR_CTRL, r);
        chk("ctrl", `SDM_CTRL_RST, r);
        bus_rd(4'h7, r);
        chk("unmapped", 32'h0, r);
        // every select code reaches the mode lines
        for (int m = 0; m < 4; m++) begin
            bus_wr(`SDM_ADDR_CTRL, 32'h1 | (m << 2));
            @(posedge clk_i);
            chk("mode", 32'(m), 32'(res));
            chk("strap mode", (m == 1 || m == 2) ? 32'h1 : 32'h0,
                32'(res_dflt));
        end
        bus_wr(`SDM_ADDR_CTRL, 32'h9);
        // second job while busy must be dropped
        bus_wr(`SDM_ADDR_STEP, 32'h0001_0002);
        bus_wr(`SDM_ADDR_STEP, 32'h0000_0005);
        wait_idle();
        chk("pos fwd", 32'h2, 32'(pos));
        bus_rd(`SDM_ADDR_STATUS, r);
        chk("dir", 32'h1, 32'(r[16]));
        chk("done", 32'h2, 32'(r[15:0]));
        bus_wr(`SDM_ADDR_STEP, 32'h0000_0001);
        wait_idle();
        chk("pos back", 32'h1, 32'(pos));
        bus_rd(`SDM_ADDR_STEP, r);
        chk("left", 32'h0, r);
        // sequencer reset line
        bus_wr(`SDM_ADDR_CTRL, 32'hB);
        @(posedge clk_i);
        chk("seq low", 32'h0, 32'(pins.sequencer_reset_n));
        bus_wr(`SDM_ADDR_CTRL, 32'h8);
        @(posedge clk_i);
        chk("seq high", 32'h1, 32'(pins.sequencer_reset_n));
        chk("en off", 32'h0, 32'(pins.enable));
        // step job refused while disabled
        bus_wr(`SDM_ADDR_STEP, 32'h0001_0003);
        repeat (40) @(posedge clk_i);
        chk("pos off", 32'h1, 32'(pos));
        chk("timing", 32'h0, 32'(bad));
        bus_rd(`SDM_ADDR_STATUS, r);
        chk("off busy", 32'h0, 32'(r[17]));
        chk("off done", 32'h3, 32'(r[15:0]));
        // thermal indicator through status
        overheat <= 1'b1;
        repeat (4) @(posedge clk_i);
        bus_rd(`SDM_ADDR_STATUS, r);
        chk("hot", 32'h1, 32'(r[18]));
        overheat <= 1'b0;
        repeat (4) @(posedge clk_i);
        bus_rd(`SDM_ADDR_STATUS, r);
        chk("cool", 32'h0, 32'(r[18]));
        // mid-run reset brings back the defaults
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        bus_wr(4'h7, 32'hF);
        bus_rd(`SDM_ADDR_CTRL, r);
        chk("ctrl again", `SDM_CTRL_RST, r);
        bus_rd(`SDM_ADDR_STATUS, r);
        chk("done again", 32'h0, 32'(r[15:0]));
        finish_test();
    end
endmodule
